// [rsb_map.svh]
// frame layout, offsets, field positions and reset values of the relay switch register banks
// assumes inclusion by bare name from every file that decodes frames or pointers
`ifndef RSB_MAP_SVH
`define RSB_MAP_SVH

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define RSB_FRAME_W          8
`define RSB_FRM_WRITE_BIT    7
`define RSB_FRM_STDDIAG_BIT  1
`define RSB_FRM_BANK_BIT     0

// ----------------------------------------------------------------
// control bank pointers
// ----------------------------------------------------------------
`define RSB_PTR_ROUTE_CH01   3'h0
`define RSB_PTR_ROUTE_CH23   3'h1
`define RSB_PTR_ROUTE_CH45   3'h2
`define RSB_PTR_ROUTE_CH67   3'h3
`define RSB_PTR_DIAG_EN_LOW  3'h4
`define RSB_PTR_DIAG_EN_HIGH 3'h5
`define RSB_PTR_COMMAND      3'h6
`define RSB_PTR_UNUSED       3'h7

// ----------------------------------------------------------------
// command register fields
// ----------------------------------------------------------------
`define RSB_CMD_WAKE_BIT     3
`define RSB_CMD_STANDBY_BIT  2
`define RSB_CMD_RESET_BIT    1
`define RSB_CMD_PENDING_BIT  0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RSB_REG_RESET        4'h0
`define RSB_TER_RESET        1'b1

`endif

// [rsb_pkg.sv]
// types of the relay switch register bank core; its serial link end uses none of them
// assumes rsb_map.svh is on the include path
package rsb_pkg;

    // ----------------------------------------------------------------
    // one received frame
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       write;
        logic [2:0] ptr;
        logic [3:0] data;
    } rsb_frame_type;

    // ----------------------------------------------------------------
    // frame tracking in the core clock domain
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_FRAME = 2'b01
    } rsb_state_type;

    // ----------------------------------------------------------------
    // what the next frame shifts out
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        RESP_STD  = 2'b00,
        RESP_CTRL = 2'b01,
        RESP_DIAG = 2'b10
    } rsb_resp_type;

endpackage

// [rsb_sync.sv]
// three-flop synchroniser for one level from a pin
// assumes the level is asynchronous to clk_i; output changes once stages two and three agree
`timescale 1ns/1ps
module rsb_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // level
    input  wire logic d_i,
    output logic      q_o
);

    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic q_ff;
    logic nxt_q;

    always_comb begin
        nxt_q = (s2_ff == s3_ff) ? s3_ff : q_ff;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_ff <= RESET_VAL;
            s2_ff <= RESET_VAL;
            s3_ff <= RESET_VAL;
            q_ff  <= RESET_VAL;
        end else begin
            s1_ff <= d_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            q_ff  <= nxt_q;
        end
    end

    assign q_o = q_ff;

endmodule

// [rsb_spi_link.sv]
// serial link end on the serial clock: shifts frames in and the response out
// assumes sclk is low at every chip-select edge and stands still while chip select is high
`timescale 1ns/1ps
`include "rsb_map.svh"
module rsb_spi_link (
    // link pins
    input  wire logic       sclk_i,
    input  wire logic       cs_n_i,
    input  wire logic       si_i,
    output logic            so_o,
    // core side, quasi-static while chip select is high
    input  wire logic [7:0] resp_i,
    input  wire logic       ter_i,
    output logic [7:0]      rx_o,
    output logic [2:0]      cnt_o,
    output logic            idle_o
);

    logic [7:0] rx_ff;
    logic [2:0] cnt_ff;
    logic       new_ff;
    logic       started_ff;
    logic [7:0] tx_ff;

    // ----------------------------------------------------------------
    // receive on falling edge, msb first
    // ----------------------------------------------------------------
    // new_ff is preset by chip select high; only a constant enters there
    always_ff @(negedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            new_ff <= 1'b1;
        end else begin
            new_ff <= 1'b0;
        end
    end

    always_ff @(negedge sclk_i) begin
        rx_ff  <= {rx_ff[6:0], si_i};
        cnt_ff <= new_ff ? 3'h1 : 3'(cnt_ff + 3'h1);
    end

    // ----------------------------------------------------------------
    // transmit on rising edge, msb first
    // ----------------------------------------------------------------
    always_ff @(posedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            started_ff <= 1'b0;
        end else begin
            started_ff <= 1'b1;
        end
    end

    always_ff @(posedge sclk_i) begin
        tx_ff <= started_ff ? {tx_ff[6:0], si_i} : resp_i;
    end

    // error flag stands until the first rising edge
    assign so_o  = started_ff ? tx_ff[7] : ter_i;
    assign rx_o  = rx_ff;
    assign cnt_o = cnt_ff;
    // high from chip select rise until the first falling clock of a frame;
    // a link-side toggle would need a reset this domain does not have
    assign idle_o = new_ff;

endmodule

// [rsb_relay_regs.sv]
// control and diagnosis register banks of an eight-channel relay switch behind a serial port
// assumes CLK_I at 40 MHz; serial clock, chip select and data arrive asynchronously on pins
`timescale 1ns/1ps
`include "rsb_map.svh"

module rsb_relay_regs (
    // core clock and reset
    input  wire logic        CLK_I,
    input  wire logic        RST_I,
    // serial port pins
    input  wire logic        SCLK_I,
    input  wire logic        CS_N_I,
    input  wire logic        SI_I,
    output logic             SO_O,
    output logic             SO_OE_O,
    // channel status
    input  wire logic [7:0]  OPEN_LOAD_I,
    input  wire logic [7:0]  FAULT_I,
    input  wire logic        AWAKE_I,
    input  wire logic        LIMP_HOME_I,
    // control bank contents
    output logic [15:0]      INPUT_ROUTE_O,
    output logic [7:0]       DIAG_ENABLE_O,
    output logic             PENDING_COMMAND_BIT_O,
    // command pulses
    output logic             WAKE_COMMAND_O,
    output logic             STANDBY_COMMAND_O,
    output logic             RESET_COMMAND_O
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic                  cs_n_s;
    logic [7:0]            link_rx;
    logic [2:0]            link_cnt;
    logic                  link_idle;
    logic                  link_idle_s;
    logic                  link_so;

    rsb_pkg::rsb_state_type state_ff;
    rsb_pkg::rsb_state_type nxt_state;
    rsb_pkg::rsb_frame_type frame;
    rsb_pkg::rsb_resp_type  resp_kind_ff;
    rsb_pkg::rsb_resp_type  nxt_resp_kind;

    logic [3:0]            route_ff [4];
    logic [3:0]            nxt_route [4];
    logic [3:0]            diag_en_ff [2];
    logic [3:0]            nxt_diag_en [2];
    logic                  pending_ff;
    logic                  nxt_pending;
    logic                  wake_ff;
    logic                  nxt_wake;
    logic                  standby_ff;
    logic                  nxt_standby;
    logic                  reset_cmd_ff;
    logic                  nxt_reset_cmd;

    logic                  ter_ff;
    logic                  nxt_ter;
    logic                  clocked_ff;
    logic                  nxt_clocked;
    logic [2:0]            resp_ptr_ff;
    logic [2:0]            nxt_resp_ptr;
    logic [7:0]            resp_ff;
    logic [7:0]            nxt_resp;
    logic                  so_oe_ff;

    logic [3:0]            diag_reg [4];
    logic [3:0]            diag_pair;
    logic [3:0]            ctrl_rdata;
    logic                  frame_ok;

    // ----------------------------------------------------------------
    // crossings
    // ----------------------------------------------------------------
    rsb_sync #(
        .RESET_VAL (1'b1)
    ) u_cs_sync (
        .clk_i (CLK_I),
        .rst_i (RST_I),
        .d_i   (CS_N_I),
        .q_o   (cs_n_s)
    );

    // no-clock flag of the link; rises with chip select, so both share one lag
    rsb_sync #(
        .RESET_VAL (1'b1)
    ) u_idle_sync (
        .clk_i (CLK_I),
        .rst_i (RST_I),
        .d_i   (link_idle),
        .q_o   (link_idle_s)
    );

    // link rx and count registers are only read once chip select is high and synchronised:
    // the serial clock is idle then, so the words are stable for the capture
    rsb_spi_link u_link (
        .sclk_i (SCLK_I),
        .cs_n_i (CS_N_I),
        .si_i   (SI_I),
        .so_o   (link_so),
        .resp_i (resp_ff),
        .ter_i  (ter_ff),
        .rx_o   (link_rx),
        .cnt_o  (link_cnt),
        .idle_o (link_idle)
    );

    // ----------------------------------------------------------------
    // diagnosis bank, read-only view of channel status
    // ----------------------------------------------------------------
    // no frame path writes here; it is only ever a read source
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_diag
            assign diag_reg[g] = {OPEN_LOAD_I[2*g+1], FAULT_I[2*g+1],
                                  OPEN_LOAD_I[2*g],   FAULT_I[2*g]};
        end
    endgenerate

    // two-bit pointer for the diagnosis bank
    assign diag_pair = diag_reg[resp_ptr_ff[1:0]];

    // ----------------------------------------------------------------
    // control bank read data
    // ----------------------------------------------------------------
    always_comb begin
        case (resp_ptr_ff)
            `RSB_PTR_ROUTE_CH01,
            `RSB_PTR_ROUTE_CH23,
            `RSB_PTR_ROUTE_CH45,
            `RSB_PTR_ROUTE_CH67:  ctrl_rdata = route_ff[resp_ptr_ff[1:0]];
            `RSB_PTR_DIAG_EN_LOW: ctrl_rdata = diag_en_ff[0];
            `RSB_PTR_DIAG_EN_HIGH: ctrl_rdata = diag_en_ff[1];
            default:              ctrl_rdata = 4'h0;
        endcase
    end

    // ----------------------------------------------------------------
    // frame decode
    // ----------------------------------------------------------------
    assign frame = link_rx;
    // a frame counts only with a whole multiple of eight clocks and at least one clock
    assign frame_ok = clocked_ff && (link_cnt == 3'h0);

    always_comb begin
        nxt_state     = state_ff;
        nxt_route     = route_ff;
        nxt_diag_en   = diag_en_ff;
        nxt_pending   = pending_ff;
        nxt_wake      = 1'b0;
        nxt_standby   = 1'b0;
        nxt_reset_cmd = 1'b0;
        nxt_ter       = ter_ff;
        nxt_clocked   = clocked_ff;
        nxt_resp_kind = resp_kind_ff;
        nxt_resp_ptr  = resp_ptr_ff;
        nxt_resp      = resp_ff;
        case (state_ff)
            rsb_pkg::ST_IDLE: begin
                if (!cs_n_s) begin
                    nxt_state = rsb_pkg::ST_FRAME;
                    nxt_clocked = 1'b0;
                    // response loaded here, so status reflects the frame start
                    case (resp_kind_ff)
                        rsb_pkg::RESP_CTRL: nxt_resp = {1'b1, resp_ptr_ff, ctrl_rdata};
                        rsb_pkg::RESP_DIAG: nxt_resp = {2'b01, resp_ptr_ff[1:0],
                                                        diag_pair};
                        default: nxt_resp = {2'b00, AWAKE_I, LIMP_HOME_I,
                                             |diag_reg[3], |diag_reg[2],
                                             |diag_reg[1], |diag_reg[0]};
                    endcase
                end
            end
            rsb_pkg::ST_FRAME: begin
                if (cs_n_s) begin
                    nxt_state     = rsb_pkg::ST_IDLE;
                    nxt_resp_kind = rsb_pkg::RESP_STD;
                    if (!frame_ok) begin
                        // bad length: command ignored, error flag shown next frame
                        nxt_ter = 1'b1;
                    end else begin
                        nxt_ter     = 1'b0;
                        nxt_pending = 1'b0;
                        if (frame.write) begin
                            case (frame.ptr)
                                `RSB_PTR_ROUTE_CH01,
                                `RSB_PTR_ROUTE_CH23,
                                `RSB_PTR_ROUTE_CH45,
                                `RSB_PTR_ROUTE_CH67: begin
                                    nxt_route[frame.ptr[1:0]] = frame.data;
                                end
                                `RSB_PTR_DIAG_EN_LOW: begin
                                    nxt_diag_en[0] = frame.data;
                                end
                                `RSB_PTR_DIAG_EN_HIGH: begin
                                    nxt_diag_en[1] = frame.data;
                                end
                                `RSB_PTR_COMMAND: begin
                                    nxt_wake      = frame.data[`RSB_CMD_WAKE_BIT];
                                    nxt_standby   = frame.data[`RSB_CMD_STANDBY_BIT];
                                    nxt_reset_cmd = frame.data[`RSB_CMD_RESET_BIT];
                                    nxt_pending   = frame.data[`RSB_CMD_PENDING_BIT];
                                    if (frame.data[`RSB_CMD_STANDBY_BIT] ||
                                        frame.data[`RSB_CMD_RESET_BIT]) begin
                                        for (int i = 0; i < 4; i++) begin
                                            nxt_route[i] = `RSB_REG_RESET;
                                        end
                                        nxt_diag_en[0] = `RSB_REG_RESET;
                                        nxt_diag_en[1] = `RSB_REG_RESET;
                                        nxt_pending    = 1'b0;
                                    end
                                end
                                default: begin
                                    // unused pointer: write dropped
                                    nxt_pending = 1'b0;
                                end
                            endcase
                        end else if (!frame.data[`RSB_FRM_STDDIAG_BIT]) begin
                            nxt_resp_ptr = frame.ptr;
                            if (frame.data[`RSB_FRM_BANK_BIT]) begin
                                nxt_resp_kind = rsb_pkg::RESP_DIAG;
                            end else begin
                                nxt_resp_kind = rsb_pkg::RESP_CTRL;
                            end
                        end
                    end
                end else if (!link_idle_s) begin
                    // a falling serial clock has been seen in this frame
                    nxt_clocked = 1'b1;
                end
            end
            default: begin
                nxt_state = rsb_pkg::ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            state_ff     <= rsb_pkg::ST_IDLE;
            for (int i = 0; i < 4; i++) begin
                route_ff[i] <= `RSB_REG_RESET;
            end
            diag_en_ff[0] <= `RSB_REG_RESET;
            diag_en_ff[1] <= `RSB_REG_RESET;
            pending_ff   <= 1'b0;
            wake_ff      <= 1'b0;
            standby_ff   <= 1'b0;
            reset_cmd_ff <= 1'b0;
            ter_ff       <= `RSB_TER_RESET;
            clocked_ff   <= 1'b0;
            resp_kind_ff <= rsb_pkg::RESP_STD;
            resp_ptr_ff  <= 3'h0;
            resp_ff      <= 8'h00;
            so_oe_ff     <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            route_ff     <= nxt_route;
            diag_en_ff   <= nxt_diag_en;
            pending_ff   <= nxt_pending;
            wake_ff      <= nxt_wake;
            standby_ff   <= nxt_standby;
            reset_cmd_ff <= nxt_reset_cmd;
            ter_ff       <= nxt_ter;
            clocked_ff   <= nxt_clocked;
            resp_kind_ff <= nxt_resp_kind;
            resp_ptr_ff  <= nxt_resp_ptr;
            resp_ff      <= nxt_resp;
            so_oe_ff     <= !cs_n_s;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // data pin mux: error flag before the first rising edge, then link shift register;
    // enable lags chip select by the sync, well inside the pin enable time
    assign SO_O                  = link_so;
    assign SO_OE_O               = so_oe_ff;
    assign INPUT_ROUTE_O         = {route_ff[3], route_ff[2], route_ff[1], route_ff[0]};
    assign DIAG_ENABLE_O         = {diag_en_ff[1], diag_en_ff[0]};
    assign PENDING_COMMAND_BIT_O = pending_ff;
    assign WAKE_COMMAND_O        = wake_ff;
    assign STANDBY_COMMAND_O     = standby_ff;
    assign RESET_COMMAND_O       = reset_cmd_ff;

endmodule

// [rsb_relay_regs_properties.sv]
// concurrent checks on the relay register bank ports, core clock domain
// assumes chip select stays high at least ten core cycles between frames
`timescale 1ns/1ps
module rsb_relay_regs_properties (
    input wire logic        CLK_I,
    input wire logic        RST_I,
    input wire logic        CS_N_I,
    input wire logic        SO_OE_O,
    input wire logic [15:0] INPUT_ROUTE_O,
    input wire logic [7:0]  DIAG_ENABLE_O,
    input wire logic        PENDING_COMMAND_BIT_O,
    input wire logic        WAKE_COMMAND_O,
    input wire logic        STANDBY_COMMAND_O,
    input wire logic        RESET_COMMAND_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    logic any_cmd;
    assign any_cmd = WAKE_COMMAND_O | STANDBY_COMMAND_O | RESET_COMMAND_O;

    // decode trails the chip-select rise through the synchroniser, so look two cycles back
    pulse_one_cycle_a: assert property (any_cmd |=> !any_cmd)
        else $error("command pulse longer than one cycle");
    power_reset_a: assert property ($fell(RST_I) |-> INPUT_ROUTE_O == 16'h0 && DIAG_ENABLE_O == 8'h0 && !PENDING_COMMAND_BIT_O)
        else $error("control bank not zero after reset");
    standby_clears_a: assert property (STANDBY_COMMAND_O |-> ##[0:1] (INPUT_ROUTE_O == 16'h0 && DIAG_ENABLE_O == 8'h0))
        else $error("standby left control bank set");
    reset_cmd_clears_a: assert property (RESET_COMMAND_O |-> ##[0:1] (INPUT_ROUTE_O == 16'h0 && !PENDING_COMMAND_BIT_O))
        else $error("reset command left control bank set");
    ctrl_frame_end_a: assert property ($changed(INPUT_ROUTE_O) || $changed(DIAG_ENABLE_O) |-> $past(CS_N_I, 2))
        else $error("control bank changed inside a frame");
    cmd_after_frame_a: assert property (any_cmd |-> $past(CS_N_I, 2))
        else $error("command pulse inside a frame");
    pending_frame_end_a: assert property ($changed(PENDING_COMMAND_BIT_O) |-> $past(CS_N_I, 2))
        else $error("pending bit changed inside a frame");
    oe_idle_off_a: assert property (CS_N_I [*8] |-> !SO_OE_O)
        else $error("serial output driven while deselected");
    oe_rise_sel_a: assert property ($rose(SO_OE_O) |-> !CS_N_I && !$past(CS_N_I, 2))
        else $error("serial output enabled without select");

    cover property (WAKE_COMMAND_O);
    cover property (STANDBY_COMMAND_O);
    cover property ($rose(PENDING_COMMAND_BIT_O));
endmodule

bind rsb_relay_regs rsb_relay_regs_properties chk_u (
    .CLK_I                 (CLK_I),
    .RST_I                 (RST_I),
    .CS_N_I                (CS_N_I),
    .SO_OE_O               (SO_OE_O),
    .INPUT_ROUTE_O         (INPUT_ROUTE_O),
    .DIAG_ENABLE_O         (DIAG_ENABLE_O),
    .PENDING_COMMAND_BIT_O (PENDING_COMMAND_BIT_O),
    .WAKE_COMMAND_O        (WAKE_COMMAND_O),
    .STANDBY_COMMAND_O     (STANDBY_COMMAND_O),
    .RESET_COMMAND_O       (RESET_COMMAND_O)
);

// [rsb_spi_master.sv]
// serial master model standing in for the system microcontroller
// assumes so_i already reads z while the device leaves the line undriven
`timescale 1ns/1ps
module rsb_spi_master (
    // link pins
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      si_o,
    input  wire logic so_i
);
    // clock rests low between frames; data in falls to its pull-down level
    // a short select pulse at start presets the link's frame flags
    initial begin
        sclk_o = 1'b0;
        si_o   = 1'b0;
        cs_n_o = 1'b0;
        #1 cs_n_o = 1'b1;
    end

    // 30 ns bit period; a bit count that is not a multiple of eight is a deliberate bad frame
    task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx,
                        output logic ter);
        rx = 16'h0;
        #7 cs_n_o = 1'b0;
        #260 ter = so_i;
        for (int i = n - 1; i >= 0; i--) begin
            si_o = tx[i];
            #10 sclk_o = 1'b1;
            #14 rx = {rx[14:0], so_i};
            #1 sclk_o = 1'b0;
            #5;
        end
        #255 cs_n_o = 1'b1;
        si_o = 1'b0;
        #400;
    endtask
endmodule

// [rsb_relay_regs_test.sv]
// self-checking bench for the relay register bank, serial master on the far side
// assumes a 40 MHz core clock and the master model in rsb_spi_master.sv
`timescale 1ns/1ps
module rsb_relay_regs_test;
    logic        clk, rst, sclk, cs_n, si, so, so_oe, so_w, awake, limp, ter;
    logic        pend, wake, stby, rstc;
    logic [7:0]  ol, flt, den;
    logic [15:0] route, rx;
    logic [3:0]  n_wake = 4'h0, n_stby = 4'h0, n_rstc = 4'h0;
    int          err_count = 0, checked = 0;

    assign so_w = so_oe ? so : 1'bz;

    rsb_relay_regs dut_u (
        .CLK_I(clk), .RST_I(rst), .SCLK_I(sclk), .CS_N_I(cs_n), .SI_I(si),
        .SO_O(so), .SO_OE_O(so_oe), .OPEN_LOAD_I(ol), .FAULT_I(flt),
        .AWAKE_I(awake), .LIMP_HOME_I(limp), .INPUT_ROUTE_O(route),
        .DIAG_ENABLE_O(den), .PENDING_COMMAND_BIT_O(pend), .WAKE_COMMAND_O(wake),
        .STANDBY_COMMAND_O(stby), .RESET_COMMAND_O(rstc)
    );
    rsb_spi_master spi_u (.sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_i(so_w));

    // pulse counters; a pulse longer than one cycle counts once per cycle it stays high
    always @(posedge clk) begin
        if (wake === 1'b1) n_wake <= n_wake + 4'h1;
        if (stby === 1'b1) n_stby <= n_stby + 4'h1;
        if (rstc === 1'b1) n_rstc <= n_rstc + 4'h1;
    end

    task automatic stop_test;
        if (err_count == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input bit ok, input string what);
        checked++;
        if (!ok) begin
            err_count++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask

    task automatic frame(input logic [7:0] tx, input int n);
        spi_u.xfer({8'h00, tx}, n, rx, ter);
    endtask

    // the second frame is a harmless standard read
    task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
        frame(cmd, 8);
        frame(8'h02, 8);
        chk(rx[7:0] === exp, "read back");
    endtask

    task automatic t_reset_values;
        for (int p = 0; p < 8; p++) begin
            rd({1'b0, p[2:0], 4'h0}, {1'b1, p[2:0], 4'h0});
        end
    endtask

    task automatic t_write_read;
        logic [3:0] v [6];
        v = '{4'h5, 4'ha, 4'hf, 4'h3, 4'hc, 4'h9};
        for (int p = 0; p < 6; p++) begin
            frame({1'b1, p[2:0], v[p]}, 8);
        end
        frame(8'hff, 8);
        chk({route, den} === {v[3], v[2], v[1], v[0], v[5], v[4]}, "outputs");
        for (int p = 0; p < 6; p++) begin
            rd({1'b0, p[2:0], 4'h0}, {1'b1, p[2:0], v[p]});
        end
        rd(8'h70, 8'hf0);
    endtask

    task automatic t_commands;
        frame(8'he1, 8);
        chk(pend === 1'b1, "pending set");
        frame(8'h95, 7);
        chk(pend === 1'b1 && route[7:4] === 4'ha, "bad frame");
        frame(8'h02, 8);
        chk(ter === 1'b1 && pend === 1'b0, "pending clear");
        for (int k = 0; k < 3; k++) begin
            frame(8'h95, 8);
            frame({4'he, 4'h8 >> k}, 8);
            chk(route[7:4] === ((k == 0) ? 4'h5 : 4'h0), "command effect");
        end
        chk({n_wake, n_stby, n_rstc} === 12'h111, "pulses");
        rd(8'h60, 8'he0);
    endtask

    // status moves between the two frames; the answer must show the new value
    task automatic t_diag;
        logic [7:0] o, f;
        for (int p = 0; p < 4; p++) begin
            o = 8'ha5 >> p;
            f = 8'h3c << p;
            frame({2'b00, p[1:0], 4'h1}, 8);
            @(posedge clk);
            ol <= o;
            flt <= f;
            frame(8'h02, 8);
            chk(rx[7:0] === {2'b01, p[1:0], o[2*p+1], f[2*p+1], o[2*p], f[2*p]}, "diag");
        end
        @(posedge clk);
        ol <= 8'h04;
        flt <= 8'h80;
        awake <= 1'b1;
        limp <= 1'b1;
        frame(8'h95, 8);
        frame(8'h02, 8);
        chk(rx[7:0] === 8'h3a, "standard");
    endtask

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        rst = 1'b1;
        ol = 8'h00;
        flt = 8'h00;
        awake = 1'b0;
        limp = 1'b0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (10) @(posedge clk);
        t_reset_values();
        t_write_read();
        t_commands();
        t_diag();
        stop_test();
    end

    // about sixty frames of some 1.2 us each
    initial begin
        #300000;
        err_count++;
        stop_test();
    end
endmodule
